// file: core/flash_status_reg_protect.sv
`timescale 1ns/10ps
`include "flash_status_map.svh"
module flash_status_reg_protect
   import flash_status_pkg::*;
#(
   parameter int STATUS_WRITE_TIME_US = 40,
   parameter int CLK_PERIOD_NS = 8,
   parameter int SW_CYCLES =
      (STATUS_WRITE_TIME_US * 1000) / CLK_PERIOD_NS
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe,
   input wire logic i_write_protect_io2_pin_n,
   input wire logic i_hw_reset_pin_n,
   input wire logic i_four_wire_cmd_mode,
   input wire pe_req_t i_pe_req,
   input wire logic i_pe_done,
   input wire logic i_pe_suspend,
   output logic o_pe_accept,
   output logic o_pe_reject,
   output status_byte_t o_status,
   output logic o_hardware_lock_mode,
   output logic o_quad_io_enable
);
   // ----------------------------------------------------------------
   // link domain: bit counter and shift register
   // ----------------------------------------------------------------
   logic fresh_reg;
   logic [4:0] link_cnt_reg;
   logic [4:0] link_cnt_next;
   logic [23:0] link_shift_reg;
   logic [7:0] opc_reg;
   logic read_flag_reg;
   logic read_flag_next;
   status_byte_t stat_meta_reg;
   status_byte_t stat_sync_reg;
   logic so_reg;
   logic so_oe_reg;
   wire logic [7:0] opc_now = {link_shift_reg[6:0], i_si};
   wire logic cnt_sat = (link_cnt_reg == `LEN_SATURATE);

   // select high arms a restart of the count for the next frame
   always_ff @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         fresh_reg <= 1'b1;
      end else begin
         fresh_reg <= 1'b0;
      end
   end

   assign link_cnt_next = fresh_reg ? 5'h01 :
      (cnt_sat ? link_cnt_reg : link_cnt_reg + 5'h01);
   assign read_flag_next = fresh_reg ? 1'b0 :
      (link_cnt_reg == `LEN_LAST_OPC_BIT &&
       opc_now == `OPC_STATUS_READ) ? 1'b1 : read_flag_reg;

   // bits enter msb first; count survives select high for the core
   always_ff @(posedge i_sclk) begin
      link_cnt_reg <= link_cnt_next;
      link_shift_reg <= {link_shift_reg[22:0], i_si};
      read_flag_reg <= read_flag_next;
   end

   // first eight bits of a frame are kept as its opcode
   always_ff @(posedge i_sclk) begin
      if (!fresh_reg && link_cnt_reg == `LEN_LAST_OPC_BIT) begin
         opc_reg <= opc_now;
      end
   end

   // status bits are independent levels, two flops each
   always_ff @(posedge i_sclk) begin
      stat_meta_reg <= o_status;
      stat_sync_reg <= stat_meta_reg;
   end

   // status out on falling edge, msb first, repeating per byte
   always_ff @(negedge i_sclk) begin
      so_reg <= stat_sync_reg[~link_cnt_reg[2:0]];
      so_oe_reg <= read_flag_reg && (link_cnt_reg >= `LEN_OPCODE);
   end

   assign o_so = so_reg;
   assign o_so_oe = so_oe_reg & ~i_cs_n;

   // ----------------------------------------------------------------
   // core domain: pin synchronisers
   // ----------------------------------------------------------------
   logic cs_meta_reg;
   logic cs_sync_reg;
   logic cs_prev_reg;
   logic wp_meta_reg;
   logic wp_sync_reg;
   logic rst_meta_reg;
   logic rst_sync_reg;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
         wp_meta_reg <= 1'b1;
         wp_sync_reg <= 1'b1;
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= 1'b1;
      end else begin
         cs_meta_reg <= i_cs_n;
         cs_sync_reg <= cs_meta_reg;
         cs_prev_reg <= cs_sync_reg;
         wp_meta_reg <= i_write_protect_io2_pin_n;
         wp_sync_reg <= wp_meta_reg;
         rst_meta_reg <= i_hw_reset_pin_n;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // frame decode at select rise
   // ----------------------------------------------------------------
   status_byte_t stat_reg;
   status_byte_t stat_next;
   core_state_t state_reg;
   core_state_t state_next;
   logic [23:0] sw_cnt_reg;
   logic [23:0] sw_cnt_next;
   logic [7:0] sw_data_reg;
   logic [7:0] sw_data_next;
   logic accept_reg;
   logic reject_reg;

   // frame ends when select rises; link regs are static by then
   wire logic frame_end = cs_sync_reg & ~cs_prev_reg;
   wire logic len_is_cmd = (link_cnt_reg == `LEN_OPCODE);
   wire logic len_one = (link_cnt_reg == `LEN_SW_ONE_BYTE);
   wire logic len_two = (link_cnt_reg == `LEN_SW_TWO_BYTES);
   wire logic opc_full = (link_cnt_reg >= `LEN_OPCODE);
   // opcode kept by the link, whatever the frame length
   wire logic [7:0] opc_end = opc_reg;
   wire logic [7:0] data_end = len_two ? link_shift_reg[15:8] :
      link_shift_reg[7:0];
   wire logic idle = (state_reg == ST_IDLE);

   // protection modes
   wire logic pins_active = ~stat_reg.quad_io_enable;
   wire logic hw_lock = stat_reg.status_lock_bit & ~wp_sync_reg &
      pins_active & ~i_four_wire_cmd_mode;
   wire logic hw_reset_low = pins_active & ~rst_sync_reg;

   // commands seen at frame end
   wire logic unlock_cmd = frame_end & len_is_cmd &
      (opc_end == `OPC_WRITE_UNLOCK);
   wire logic disable_cmd = frame_end & len_is_cmd &
      (opc_end == `OPC_WRITE_DISABLE);
   wire logic sw_seen = frame_end & opc_full &
      (opc_end == `OPC_STATUS_WRITE);
   wire logic sw_len_ok = len_one | len_two;
   wire logic sw_start = sw_seen & sw_len_ok & idle &
      stat_reg.write_latch_flag & ~hw_lock;

   // program or erase gate
   wire logic level_zero = (stat_reg.protect_level == `LEVEL_NONE);
   wire logic chip_ok = (i_pe_req.kind != PE_CHIP_WIPE) | level_zero;
   wire logic pe_ok = i_pe_req.valid & idle & ~sw_start &
      stat_reg.write_latch_flag & ~i_pe_req.in_protected &
      chip_ok;
   wire logic sw_done = (state_reg == ST_SW_BUSY) &&
      (sw_cnt_reg == 24'h00_0000);
   // written byte seen through the status layout
   wire status_byte_t sw_fields = status_byte_t'(sw_data_reg);

   // ----------------------------------------------------------------
   // state and status next values
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      stat_next = stat_reg;
      sw_cnt_next = sw_cnt_reg;
      sw_data_next = sw_data_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (sw_start) begin
               state_next = ST_SW_BUSY;
               sw_cnt_next = 24'(SW_CYCLES - 1);
               sw_data_next = data_end;
            end else if (pe_ok) begin
               state_next = ST_PE_BUSY;
            end
         end
         ST_SW_BUSY: begin
            if (sw_done) begin
               state_next = ST_IDLE;
               stat_next.status_lock_bit = sw_fields.status_lock_bit;
               stat_next.quad_io_enable = sw_fields.quad_io_enable;
               stat_next.protect_level = sw_fields.protect_level;
               stat_next.write_latch_flag = 1'b0;
            end else begin
               sw_cnt_next = sw_cnt_reg - 24'h00_0001;
            end
         end
         ST_PE_BUSY: begin
            if (i_pe_done) begin
               state_next = ST_IDLE;
               stat_next.write_latch_flag = 1'b0;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // latch set only when free; clearing events follow
      if (unlock_cmd && idle) begin
         stat_next.write_latch_flag = 1'b1;
      end
      if (disable_cmd || i_pe_suspend || hw_reset_low) begin
         stat_next.write_latch_flag = 1'b0;
      end
      stat_next.write_busy_flag = (state_next != ST_IDLE);
   end

   // status register and cycle state
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         stat_reg <= `STATUS_RESET;
         state_reg <= ST_IDLE;
         sw_cnt_reg <= 24'h00_0000;
         sw_data_reg <= `STATUS_RESET;
      end else begin
         stat_reg <= stat_next;
         state_reg <= state_next;
         sw_cnt_reg <= sw_cnt_next;
         sw_data_reg <= sw_data_next;
      end
   end

   // request answers, one cycle each
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         accept_reg <= 1'b0;
         reject_reg <= 1'b0;
      end else begin
         accept_reg <= pe_ok;
         reject_reg <= i_pe_req.valid & ~pe_ok;
      end
   end

   assign o_status = stat_reg;
   assign o_pe_accept = accept_reg;
   assign o_pe_reject = reject_reg;
   assign o_hardware_lock_mode = hw_lock;
   assign o_quad_io_enable = stat_reg.quad_io_enable;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   a_busy_layout: assert property (
      o_status.write_busy_flag == (state_reg != ST_IDLE))
      else $error("busy flag does not match cycle state");
   a_sw_busy_run: assert property (
      sw_start |=> o_status.write_busy_flag [*8])
      else $error("busy dropped early in status write");
   a_sw_end_clear: assert property (
      sw_done |=> !o_status.write_busy_flag &&
      !o_status.write_latch_flag)
      else $error("cycle end left busy or latch set");
   a_no_latch_reject: assert property (
      (sw_seen && !stat_reg.write_latch_flag && idle) |=>
      state_reg == ST_IDLE)
      else $error("status write taken without latch");
   a_bad_len_reject: assert property (
      (sw_seen && !len_one && !len_two) |=> $stable(stat_reg))
      else $error("status write of bad length changed status");
   a_hw_lock_refuse: assert property (
      (sw_seen && hw_lock) |=> !o_status.write_busy_flag ||
      $past(o_status.write_busy_flag))
      else $error("status write ran in hardware lock");
   a_pe_protect: assert property (
      o_pe_accept |-> $past(!i_pe_req.in_protected &&
      (i_pe_req.kind != PE_CHIP_WIPE || level_zero)))
      else $error("program or erase passed the protect gate");
   a_hw_lock_def: assert property (
      o_hardware_lock_mode == (stat_reg.status_lock_bit &&
      !wp_sync_reg && !stat_reg.quad_io_enable &&
      !i_four_wire_cmd_mode))
      else $error("hardware lock mode wrong");
   a_write_fields: assert property (
      sw_done |=> o_status[7:2] == $past(sw_data_reg[7:2]))
      else $error("status write stored wrong fields");
   a_latch_set: assert property (
      (unlock_cmd && idle && !i_pe_suspend && !hw_reset_low) |=>
      o_status.write_latch_flag)
      else $error("write unlock did not set the latch");
   a_latch_clear: assert property (
      (disable_cmd || i_pe_suspend || hw_reset_low) |=>
      !o_status.write_latch_flag)
      else $error("latch survived a clearing event");
   a_pe_busy: assert property (
      o_pe_accept |-> o_status.write_busy_flag)
      else $error("program or erase accepted without busy");
   a_field_hold: assert property (
      !sw_done |=> $stable(o_status[7:2]))
      else $error("lock, quad or level changed outside a write");
   a_quad_no_lock: assert property (
      o_quad_io_enable |-> !o_hardware_lock_mode)
      else $error("hardware lock active with quad enabled");

   c_status_write: cover property (sw_done ##1 !o_status.write_busy_flag);
   c_reset_pin_clear: cover property (hw_reset_low && o_status.write_latch_flag);
   c_hw_lock_reject: cover property (sw_seen && hw_lock);
   c_pe_accept: cover property (o_pe_accept);
   c_chip_blocked: cover property (
      i_pe_req.valid && i_pe_req.kind == PE_CHIP_WIPE && !level_zero);
endmodule : flash_status_reg_protect

// file: core/flash_status_map.svh
`ifndef FLASH_STATUS_MAP_SVH
`define FLASH_STATUS_MAP_SVH
// ----------------------------------------------------------------
// opcodes of the serial link
// ----------------------------------------------------------------
`define OPC_WRITE_UNLOCK 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_STATUS_WRITE 8'h01
// ----------------------------------------------------------------
// bit counts of a frame
// ----------------------------------------------------------------
`define LEN_OPCODE 5'h08
`define LEN_SW_ONE_BYTE 5'h10
`define LEN_SW_TWO_BYTES 5'h18
`define LEN_SATURATE 5'h1f
`define LEN_LAST_OPC_BIT 5'h07
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define STATUS_RESET 8'h00
`define LEVEL_NONE 4'h0
`endif

// file: core/flash_status_pkg.sv
package flash_status_pkg;
   // status byte, msb first: lock, quad, level[3:0], latch, busy
   typedef struct packed {
      logic status_lock_bit;
      logic quad_io_enable;
      logic [3:0] protect_level;
      logic write_latch_flag;
      logic write_busy_flag;
   } status_byte_t;
   // kinds of program or erase request
   typedef enum logic [2:0] {
      PE_PAGE_PROGRAM = 3'h0,
      PE_SMALL_WIPE = 3'h1,
      PE_MID_WIPE = 3'h2,
      PE_LARGE_WIPE = 3'h3,
      PE_CHIP_WIPE = 3'h4
   } pe_kind_t;
   typedef struct packed {
      logic valid;
      pe_kind_t kind;
      logic in_protected;
   } pe_req_t;
   // core states, gray along idle -> write -> program
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SW_BUSY = 2'h1,
      ST_PE_BUSY = 2'h3
   } core_state_t;
endpackage : flash_status_pkg

// file: tb/flash_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------
// host controller on the serial status link
// ---------------------------------------------
module flash_host_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_si,
   input wire logic i_so
);
   // link idles deselected, clock parked low
   initial begin
      o_sclk = 1'b0;
      o_cs_n <= 1'b1; // late, so the count restart sees the rise
      o_si = 1'b0;
   end
   // one frame: n bits msb first from d, reply byte after opcode
   task automatic xfer(input int n, input logic [23:0] d,
                       output logic [7:0] rd);
      int k;
      rd = 8'h00;
      o_cs_n = 1'b0;
      #83; // odd lead keeps the link phase apart from the core clock
      for (k = 0; k < n; k++) begin
         o_si = d[23 - k];
         #80;
         o_sclk = 1'b1;
         if (k >= 8 && k < 16) rd = {rd[6:0], i_so};
         #80;
         o_sclk = 1'b0;
      end
      #80;
      o_cs_n = 1'b1;
      o_si = ~o_si; // released line shows no stale bit
      #160;
   endtask : xfer
endmodule : flash_host_model

// file: tb/tb_top.sv
`timescale 1ns/10ps
`include "flash_status_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   miscompares++; $display("CHECK FAILED t=%0t got %h exp %h", \
   $time, g, e); end end
module tb_top;
   import flash_status_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sclk, cs_n, si, so, so_oe;
   logic wp_n = 1'b1;
   logic hw_rst_n = 1'b1;
   logic four_wire = 1'b0;
   pe_req_t pe_req = '0;
   logic pe_done = 1'b0;
   logic pe_suspend = 1'b0;
   logic accept, reject, hw_lock, quad;
   status_byte_t status;
   logic [7:0] rd;
   int miscompares = 0;
   int checks_done = 0;
   // ---------------------------------------------
   // clock, parts
   // ---------------------------------------------
   always #4 clk = ~clk;
   // released serial out shows the inverse of its last bit
   wire logic so_line = so_oe ? so : ~so;
   flash_status_reg_protect #(.SW_CYCLES(600)) flash_status_reg_protect_i (
      .i_clk(clk), .i_srst(srst), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_si(si), .o_so(so), .o_so_oe(so_oe),
      .i_write_protect_io2_pin_n(wp_n), .i_hw_reset_pin_n(hw_rst_n),
      .i_four_wire_cmd_mode(four_wire), .i_pe_req(pe_req),
      .i_pe_done(pe_done), .i_pe_suspend(pe_suspend),
      .o_pe_accept(accept), .o_pe_reject(reject), .o_status(status),
      .o_hardware_lock_mode(hw_lock), .o_quad_io_enable(quad));
   flash_host_model flash_host_model_i (
      .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so_line));
   // ---------------------------------------------
   // access tasks
   // ---------------------------------------------
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic read_st(input logic [7:0] e);
      flash_host_model_i.xfer(16, {`OPC_STATUS_READ, 16'h0000}, rd);
      `CHK(rd, e)
   endtask : read_st
   task automatic unlock;
      flash_host_model_i.xfer(8, {`OPC_WRITE_UNLOCK, 16'h0000}, rd);
   endtask : unlock
   task automatic write_st(input int n, input logic [7:0] v);
      flash_host_model_i.xfer(n, {`OPC_STATUS_WRITE, v, 8'h00}, rd);
   endtask : write_st
   // busy polled to 0 first, then latch
   task automatic wait_idle;
      int n;
      n = 0;
      while (status.write_busy_flag !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      `CHK(status.write_busy_flag, 1'b0)
      `CHK(status.write_latch_flag, 1'b0)
   endtask : wait_idle
   task automatic pe(input pe_kind_t k, input logic p, input logic e);
      @(negedge clk);
      pe_req = {1'b1, k, p};
      @(negedge clk);
      pe_req.valid = 1'b0;
      `CHK({accept, reject}, {e, ~e})
   endtask : pe
   task automatic finish_pe;
      `CHK(status.write_busy_flag, 1'b1)
      @(negedge clk);
      pe_done = 1'b1;
      @(negedge clk);
      pe_done = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(status[1:0], 2'h0)
   endtask : finish_pe
   // ---------------------------------------------
   // test sequence
   // ---------------------------------------------
   initial begin
      repeat (10) @(negedge clk);
      srst = 1'b0;
      repeat (5) @(negedge clk);
      read_st(8'h00);
      write_st(16, 8'h3c);
      repeat (20) @(negedge clk);
      read_st(8'h00);
      unlock();
      read_st(8'h02);
      write_st(16, 8'h3f);
      read_st(8'h03);
      wait_idle();
      read_st(8'h3c);
      $display("test basic write done");
      unlock();
      write_st(12, 8'h00);
      read_st(8'h3e);
      write_st(24, 8'h00);
      wait_idle();
      read_st(8'h00);
      $display("test frame length done");
      unlock();
      pe(PE_CHIP_WIPE, 1'b0, 1'b1);
      finish_pe();
      unlock();
      write_st(16, 8'h04);
      wait_idle();
      unlock();
      for (int k = 0; k < 5; k++) pe(pe_kind_t'(k), 1'b1, 1'b0);
      pe(PE_CHIP_WIPE, 1'b0, 1'b0);
      pe(PE_PAGE_PROGRAM, 1'b0, 1'b1);
      finish_pe();
      unlock();
      @(negedge clk);
      `CHK(status.write_latch_flag, 1'b1)
      pe_suspend = 1'b1;
      @(negedge clk);
      pe_suspend = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(status.write_latch_flag, 1'b0)
      unlock();
      @(negedge clk);
      `CHK(status.write_latch_flag, 1'b1)
      hw_rst_n = 1'b0;
      repeat (4) @(negedge clk);
      `CHK(status.write_latch_flag, 1'b0)
      hw_rst_n = 1'b1;
      $display("test program erase done");
      wp_n = 1'b0;
      unlock();
      write_st(16, 8'h80);
      wait_idle();
      repeat (5) @(negedge clk);
      `CHK(hw_lock, 1'b1)
      unlock();
      write_st(16, 8'h00);
      repeat (40) @(negedge clk);
      `CHK(status, 8'h82)
      four_wire = 1'b1;
      @(negedge clk);
      `CHK(hw_lock, 1'b0)
      four_wire = 1'b0;
      wp_n = 1'b1;
      repeat (5) @(negedge clk);
      `CHK(hw_lock, 1'b0)
      write_st(16, 8'hc0);
      wait_idle();
      read_st(8'hc0);
      unlock();
      @(negedge clk);
      wp_n = 1'b0;
      hw_rst_n = 1'b0;
      repeat (5) @(negedge clk);
      `CHK({hw_lock, quad}, 2'b01)
      `CHK(status.write_latch_flag, 1'b1)
      hw_rst_n = 1'b1;
      $display("test protection modes done");
      complete_run();
   end
   // watchdog sized well above the expected run
   initial begin
      #400000;
      miscompares++;
      complete_run();
   end
endmodule : tb_top
